/* design/ccau_top.sv */
// Calendar clock with alarms, rollover events and capture word
`timescale 1ns/100ps
module ccau_top
	import ccau_pkg::*;
#(
	parameter int unsigned DIV_W = 10
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	input wire logic sw_reset,
	input wire logic timer_power_domain,
	input wire logic capture_trig,
	output logic [21:0] timer_capture_value,
	output logic [31:0] time_word,
	output logic irq
);
	logic [4:0] ctrl_ff;
	logic [DIV_W-1:0] div_int_ff, div_frac_ff, tick_div_denominator_ff;
	logic div_en_ff;
	logic [DIV_W-1:0] cnt_ff, acc_ff;
	logic extra_ff;
	logic [6:0] hund_ff;
	logic [5:0] sec_ff, min_ff;
	logic [4:0] hour_ff;
	logic [2:0] wday_ff;
	logic [4:0] date_ff;
	logic [3:0] month_ff;
	logic [11:0] year_ff;
	logic [31:0] alm_time_ff, alm_cal_ff;
	logic [5:0] alm_en_ff;
	logic [EV_N-1:0] mask_ff, flags_ff;
	logic stepped_ff;
	logic [31:0] rdata_ff;
	logic [21:0] cap_ff;

	wire hour_format_select = ctrl_ff[CB_HOUR_FMT];
	wire time_dis = ctrl_ff[CB_TIME_DIS];
	wire cal_dis = ctrl_ff[CB_CAL_DIS];
	wire wr_ctrl = wr && addr == OFF_CTRL;
	wire wr_div = wr && addr == OFF_DIV;
	wire wr_denom = wr && addr == OFF_DENOM;
	wire wr_time = wr && addr == OFF_TIME;
	wire wr_cal = wr && addr == OFF_CAL;
	wire wr_atime = wr && addr == OFF_ALM_TIME;
	wire wr_acal = wr && addr == OFF_ALM_CAL;
	wire wr_aen = wr && addr == OFF_ALM_EN;
	wire wr_ien = wr && addr == OFF_INT_EN;
	wire wr_idis = wr && addr == OFF_INT_DIS;
	wire wr_fclr = wr && addr == OFF_FLAGS;
	wire wr_fset = wr && addr == OFF_FLAG_SET;
	// Software reset only touches time state when retention is off
	wire sw_clear = sw_reset && !ctrl_ff[CB_KEEP];

	// Fractional divider: period is int cycles, plus one when the fraction overflows
	wire [DIV_W:0] lim = {1'b0, div_int_ff} + {{DIV_W{1'b0}}, extra_ff};
	wire [DIV_W:0] frac_sum = {1'b0, acc_ff} + {1'b0, div_frac_ff};
	wire frac_carry = frac_sum >= {1'b0, tick_div_denominator_ff};
	wire [DIV_W:0] frac_next = frac_carry ? frac_sum - {1'b0, tick_div_denominator_ff} : frac_sum;
	wire cnt_done = {1'b0, cnt_ff} + {{DIV_W{1'b0}}, 1'b1} >= lim;
	// Sleep does not gate the tick; a cleared divider enable or loss of the timer domain does
	wire tick = div_en_ff && timer_power_domain && cnt_done;

	function automatic logic is_leap(input logic [11:0] y);
		is_leap = (y % 12'd4 == 12'd0 && y % 12'd100 != 12'd0) || y % 12'd400 == 12'd0;
	endfunction : is_leap

	function automatic logic [4:0] month_days(input logic [3:0] m, input logic [11:0] y);
		case (m)
			4'h2: month_days = is_leap(y) ? 5'h1d : 5'h1c;
			4'h4, 4'h6, 4'h9, 4'hb: month_days = 5'h1e;
			default: month_days = 5'h1f;
		endcase
	endfunction : month_days

	// Presented hour: internal count is always 0-23
	wire pm = hour_ff >= HOUR_NOON;
	wire [4:0] hour12 = hour_ff == 5'h00 ? HOUR_NOON : (hour_ff > HOUR_NOON ? hour_ff - HOUR_NOON : hour_ff);
	wire [4:0] hour_pres = hour_format_select ? hour12 : hour_ff;
	wire pm_pres = hour_format_select && pm;
	wire [4:0] wr_h12 = wdata[28:24] == HOUR_NOON ? 5'h00 : wdata[28:24];
	wire [4:0] wr_hour = hour_format_select ? wr_h12 + (wdata[30] ? HOUR_NOON : 5'h00) : wdata[28:24];
	wire [31:0] time_rd = {1'b0, pm_pres, 1'b0, hour_pres, 2'h0, min_ff, 2'h0, sec_ff, 1'b0, hund_ff};
	wire [31:0] cal_rd = {year_ff, month_ff, 3'h0, date_ff, 5'h00, wday_ff};

	logic [6:0] nxt_hund;
	logic [5:0] nxt_sec, nxt_min;
	logic [4:0] nxt_hour, nxt_date;
	logic [2:0] nxt_wday;
	logic [3:0] nxt_month;
	logic [11:0] nxt_year;
	logic [EV_N-1:0] ev;
	logic day_carry;

	always_comb begin
		nxt_hund = hund_ff;
		nxt_sec = sec_ff;
		nxt_min = min_ff;
		nxt_hour = hour_ff;
		nxt_wday = wday_ff;
		nxt_date = date_ff;
		nxt_month = month_ff;
		nxt_year = year_ff;
		ev = '0;
		day_carry = 1'b0;
		if (tick && !time_dis) begin
			ev[EV_HUND] = 1'b1;
			nxt_hund = hund_ff + 7'h01;
			if (hund_ff == HUND_MAX) begin
				nxt_hund = 7'h00;
				ev[EV_SEC] = 1'b1;
				nxt_sec = sec_ff + 6'h01;
				if (sec_ff == MINSEC_MAX) begin
					nxt_sec = 6'h00;
					ev[EV_MIN] = 1'b1;
					nxt_min = min_ff + 6'h01;
					if (min_ff == MINSEC_MAX) begin
						nxt_min = 6'h00;
						ev[EV_HOUR] = 1'b1;
						nxt_hour = hour_ff + 5'h01;
						ev[EV_HALF] = hour_ff == HOUR_NOON - 5'h01;
						if (hour_ff == HOUR_MAX) begin
							nxt_hour = 5'h00;
							ev[EV_HALF] = 1'b1;
							day_carry = 1'b1;
						end
					end
				end
			end
		end
		if (day_carry && !cal_dis) begin
			ev[EV_DAY] = 1'b1;
			nxt_wday = wday_ff == WDAY_MAX ? 3'h0 : wday_ff + 3'h1;
			ev[EV_WEEK] = wday_ff == WDAY_MAX;
			nxt_date = date_ff + 5'h01;
			if (date_ff >= month_days(month_ff, year_ff)) begin
				nxt_date = 5'h01;
				ev[EV_MONTH] = 1'b1;
				nxt_month = month_ff + 4'h1;
				if (month_ff == MONTH_MAX) begin
					nxt_month = 4'h1;
					ev[EV_YEAR] = 1'b1;
					// Past 2999 the count folds back to 1900
					nxt_year = year_ff == YEAR_MAX ? YEAR_MIN : year_ff + 12'h001;
				end
			end
		end
	end

	// Alarm compares against the fields as presented to software
	wire [5:0] fld_ok = {
		month_ff == alm_cal_ff[19:16],
		date_ff == alm_cal_ff[12:8],
		hour_pres == alm_time_ff[28:24] && pm_pres == alm_time_ff[30],
		min_ff == alm_time_ff[21:16],
		sec_ff == alm_time_ff[13:8],
		hund_ff == alm_time_ff[6:0]
	};
	wire alm_match = alm_en_ff != 6'h00 && (fld_ok | ~alm_en_ff) == 6'h3f;
	// Checked the cycle after a step so the new time is compared
	wire alm_hit = stepped_ff && alm_match;
	wire [EV_N-1:0] ev_set = ev | {{(EV_N-1){1'b0}}, alm_hit} | (wr_fset ? wdata[EV_N-1:0] : '0);
	wire [EV_N-1:0] flag_clr = wr_fclr ? wdata[EV_N-1:0] : '0;

	wire [31:0] rd_mux =
		addr == OFF_CTRL ? {27'h0, ctrl_ff} :
		addr == OFF_DIV ? {11'h0, div_en_ff, div_frac_ff, div_int_ff} :
		addr == OFF_DENOM ? {22'h0, tick_div_denominator_ff} :
		addr == OFF_TIME ? time_rd :
		addr == OFF_CAL ? cal_rd :
		addr == OFF_ALM_TIME ? alm_time_ff :
		addr == OFF_ALM_CAL ? alm_cal_ff :
		addr == OFF_ALM_EN ? {26'h0, alm_en_ff} :
		addr == OFF_INT_MASK ? {22'h0, mask_ff} :
		addr == OFF_FLAGS ? {22'h0, flags_ff} : 32'h0;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ctrl_ff <= 5'h03;
			div_int_ff <= RST_DIV_INT;
			div_frac_ff <= RST_DIV_FRAC;
			tick_div_denominator_ff <= RST_DIV_DENOM;
			div_en_ff <= 1'b0;
			cnt_ff <= '0;
			acc_ff <= '0;
			extra_ff <= 1'b0;
		end else begin
			if (wr_ctrl) ctrl_ff <= wdata[4:0];
			if (wr_div) div_int_ff <= wdata[DIV_W-1:0];
			if (wr_div) div_frac_ff <= wdata[DIV_FRAC_LSB +: DIV_W];
			if (wr_div) div_en_ff <= wdata[DIV_EN_BIT];
			if (wr_denom) tick_div_denominator_ff <= wdata[DIV_W-1:0];
			cnt_ff <= (!div_en_ff || cnt_done) ? '0 : cnt_ff + 1'b1;
			if (tick) begin
				acc_ff <= frac_next[DIV_W-1:0];
				extra_ff <= frac_carry;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n || sw_clear) begin
			{hund_ff, sec_ff, min_ff, hour_ff, wday_ff} <= '0;
			date_ff <= 5'h01;
			month_ff <= 4'h1;
			year_ff <= YEAR_Y2K;
		end else begin
			{hund_ff, sec_ff, min_ff, hour_ff} <= wr_time ?
				{wdata[6:0], wdata[13:8], wdata[21:16], wr_hour} : {nxt_hund, nxt_sec, nxt_min, nxt_hour};
			{year_ff, month_ff, date_ff, wday_ff} <= wr_cal ?
				{wdata[31:20], wdata[19:16], wdata[12:8], wdata[2:0]} : {nxt_year, nxt_month, nxt_date, nxt_wday};
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			alm_time_ff <= '0;
			alm_cal_ff <= '0;
			alm_en_ff <= '0;
			mask_ff <= '0;
			flags_ff <= '0;
			stepped_ff <= 1'b0;
			rdata_ff <= '0;
			cap_ff <= '0;
		end else begin
			if (wr_atime) alm_time_ff <= wdata;
			if (wr_acal) alm_cal_ff <= wdata;
			// A single-shot alarm disarms itself after firing
			if (wr_aen) alm_en_ff <= wdata[5:0];
			else if (alm_hit && !ctrl_ff[CB_RECUR]) alm_en_ff <= '0;
			if (wr_ien) mask_ff <= mask_ff | wdata[EV_N-1:0];
			if (wr_idis) mask_ff <= mask_ff & ~wdata[EV_N-1:0];
			// A set in the cycle of a clear wins
			flags_ff <= (flags_ff & ~flag_clr) | ev_set;
			stepped_ff <= ev[EV_HUND];
			rdata_ff <= rd ? rd_mux : 32'h0;
			if (capture_trig) cap_ff <= time_word[21:0];
		end
	end

	assign time_word = {4'h0, wday_ff, pm_pres, hour_pres, min_ff, sec_ff, hund_ff};
	assign timer_capture_value = cap_ff;
	assign rdata = rdata_ff;
	assign irq = (flags_ff & mask_ff) != '0;

	hund_range_a: assert property (@(posedge clock) disable iff (!rst_n)
		$past(rst_n) && !$past(wr_time) |-> hund_ff <= HUND_MAX) else $error("hundredths out of range");
	hour_range_a: assert property (@(posedge clock) disable iff (!rst_n)
		!$past(wr_time) && $past(rst_n) |-> hour_pres <= HOUR_MAX && (!hour_format_select || hour_pres != 5'h00))
		else $error("hour out of range");
	tick_gate_a: assert property (@(posedge clock) disable iff (!rst_n)
		!div_en_ff && !wr_time && !sw_clear |=> $stable(hund_ff)) else $error("time moved without divider enable");
	hund_step_a: assert property (@(posedge clock) disable iff (!rst_n)
		tick && !time_dis && hund_ff < HUND_MAX && !wr_time && !sw_clear |=> hund_ff == $past(hund_ff) + 7'h01)
		else $error("hundredths did not step");
	time_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
		time_dis && !wr_time && !sw_clear |=> $stable(hund_ff) && $stable(min_ff)) else $error("time ran while disabled");
	date_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
		cal_dis && !wr_cal && !sw_clear |=> $stable(date_ff) && $stable(year_ff)) else $error("date ran while disabled");
	flag_set_a: assert property (@(posedge clock) disable iff (!rst_n)
		ev_set != '0 |=> (flags_ff & $past(ev_set)) == $past(ev_set)) else $error("event flag lost");
	int_enable_a: assert property (@(posedge clock) disable iff (!rst_n)
		wr_ien |=> (mask_ff & $past(wdata[EV_N-1:0])) == $past(wdata[EV_N-1:0])) else $error("enable write lost");
	irq_drive_a: assert property (@(posedge clock) disable iff (!rst_n)
		(ev_set & mask_ff) != '0 && !wr_idis |=> irq) else $error("masked-in event gave no interrupt");
	oneshot_a: assert property (@(posedge clock) disable iff (!rst_n)
		alm_hit && !ctrl_ff[CB_RECUR] && !wr_aen |=> alm_en_ff == 6'h00 ##1 !alm_hit) else $error("one-shot alarm rearmed");
	capture_a: assert property (@(posedge clock) disable iff (!rst_n)
		capture_trig |=> timer_capture_value == $past(time_word[21:0])) else $error("capture mismatch");
	keep_a: assert property (@(posedge clock) disable iff (!rst_n)
		sw_reset && ctrl_ff[CB_KEEP] && !wr_cal && !cal_dis && !day_carry |=> $stable(date_ff))
		else $error("retained date cleared");
endmodule : ccau_top

/* design/ccau_pkg.sv */
// Constants shared by the calendar clock and alarm unit
package ccau_pkg;
	localparam int unsigned CLK_MHZ = 250;
	localparam int unsigned TICK_PERIOD_MS = 10;
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_DIV = 8'h04;
	localparam logic [7:0] OFF_DENOM = 8'h08;
	localparam logic [7:0] OFF_TIME = 8'h0c;
	localparam logic [7:0] OFF_CAL = 8'h10;
	localparam logic [7:0] OFF_ALM_TIME = 8'h14;
	localparam logic [7:0] OFF_ALM_CAL = 8'h18;
	localparam logic [7:0] OFF_ALM_EN = 8'h1c;
	localparam logic [7:0] OFF_INT_EN = 8'h20;
	localparam logic [7:0] OFF_INT_DIS = 8'h24;
	localparam logic [7:0] OFF_INT_MASK = 8'h28;
	localparam logic [7:0] OFF_FLAGS = 8'h2c;
	localparam logic [7:0] OFF_FLAG_SET = 8'h30;
	// Control and divider register bit positions
	localparam int unsigned CB_TIME_DIS = 0;
	localparam int unsigned CB_CAL_DIS = 1;
	localparam int unsigned CB_HOUR_FMT = 2;
	localparam int unsigned CB_KEEP = 3;
	localparam int unsigned CB_RECUR = 4;
	localparam int unsigned DIV_EN_BIT = 20;
	localparam int unsigned DIV_FRAC_LSB = 10;
	// Event flag positions
	localparam int unsigned EV_ALARM = 0;
	localparam int unsigned EV_HUND = 1;
	localparam int unsigned EV_SEC = 2;
	localparam int unsigned EV_MIN = 3;
	localparam int unsigned EV_HOUR = 4;
	localparam int unsigned EV_HALF = 5;
	localparam int unsigned EV_DAY = 6;
	localparam int unsigned EV_WEEK = 7;
	localparam int unsigned EV_MONTH = 8;
	localparam int unsigned EV_YEAR = 9;
	localparam int unsigned EV_N = 10;
	// Reset values and field limits
	localparam logic [9:0] RST_DIV_INT = 10'h147;
	localparam logic [9:0] RST_DIV_FRAC = 10'h2a8;
	localparam logic [9:0] RST_DIV_DENOM = 10'h3e8;
	localparam logic [6:0] HUND_MAX = 7'h63;
	localparam logic [5:0] MINSEC_MAX = 6'h3b;
	localparam logic [4:0] HOUR_MAX = 5'h17;
	localparam logic [4:0] HOUR_NOON = 5'h0c;
	localparam logic [2:0] WDAY_MAX = 3'h6;
	localparam logic [3:0] MONTH_MAX = 4'hc;
	localparam logic [11:0] YEAR_MIN = 12'h76c;
	localparam logic [11:0] YEAR_MAX = 12'hbb7;
	localparam logic [11:0] YEAR_Y2K = 12'h7d0;
endpackage : ccau_pkg

/* verif/tb.sv */
// Register-level testbench for the calendar clock and alarm unit
`timescale 1ns/100ps
module tb;
	import ccau_pkg::*;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic sw_reset = 1'b0;
	logic timer_power_domain = 1'b1;
	logic capture_trig = 1'b0;
	logic [31:0] rdata;
	logic [21:0] timer_capture_value;
	logic [31:0] time_word;
	logic irq;
	int miscompares = 0;
	int checks = 0;
	logic [31:0] v;
	// Rollover table: control, time, calendar, expected time, calendar, flags, alarm enable
	logic [31:0] t_ctl[5] = '{32'h10, 32'h0, 32'h0, 32'h0, 32'h4};
	logic [31:0] t_tim[5] = '{32'h173b3b63, 32'h173b3b63, 32'h173b3b63, 32'h173b3b63, 32'h0b3b3b63};
	logic [31:0] t_cal[5] = '{32'h7d021c06, 32'h7d021d03, 32'h76c21c02, 32'hbb7c1f05, 32'h7d010100};
	logic [31:0] t_et[5] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h4c000000};
	logic [31:0] t_ec[5] = '{32'h7d021d00, 32'h7d030104, 32'h76c30103, 32'h76c10106, 32'h7d010100};
	logic [31:0] t_ef[5] = '{32'hff, 32'h17f, 32'h17e, 32'h37e, 32'h3e};
	logic [31:0] t_aen[5] = '{32'h1, 32'h1, 32'h0, 32'h0, 32'h0};
	// Frozen cases: control, divider, power, register that must hold
	logic [31:0] f_ctl[4] = '{32'h0, 32'h0, 32'h1, 32'h2};
	logic [31:0] f_div[4] = '{32'h2, 32'h100002, 32'h100002, 32'h100002};
	logic f_pwr[4] = '{1'b1, 1'b0, 1'b1, 1'b1};
	logic [7:0] f_reg[4] = '{OFF_TIME, OFF_TIME, OFF_TIME, OFF_CAL};

	ccau_top ccau_top_inst (.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .sw_reset(sw_reset), .timer_power_domain(timer_power_domain),
		.capture_trig(capture_trig), .timer_capture_value(timer_capture_value), .time_word(time_word), .irq(irq));

	initial begin
		forever #2 clock = ~clock;
	end

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clock);
		wr <= 1'b0;
	endtask : wr_reg

	// Read data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clock);
		rd <= 1'b1;
		addr <= a;
		@(posedge clock);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : rd_reg

	task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		rd_reg(a, d);
		check(name, d, exp);
	endtask : rd_chk

	task automatic stop_test;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : stop_test

	// Long divider period, so exactly one tick lands before it is switched off again
	task automatic one_tick(input int i);
		int n;
		wr_reg(OFF_DIV, 32'h0);
		wr_reg(OFF_CTRL, t_ctl[i]);
		wr_reg(OFF_TIME, t_tim[i]);
		wr_reg(OFF_CAL, t_cal[i]);
		wr_reg(OFF_ALM_EN, t_aen[i]);
		wr_reg(OFF_FLAGS, 32'h3ff);
		wr_reg(OFF_DIV, 32'h1003ff);
		n = 0;
		v = 32'h0;
		while (v[EV_HUND] !== 1'b1 && n < 1500) begin
			rd_reg(OFF_FLAGS, v);
			n++;
		end
		wr_reg(OFF_DIV, 32'h0);
		rd_chk("time", OFF_TIME, t_et[i]);
		rd_chk("cal", OFF_CAL, t_ec[i]);
		rd_chk("flags", OFF_FLAGS, t_ef[i]);
		rd_chk("alarm_en", OFF_ALM_EN, t_aen[i] & {27'h0, t_ctl[i][4], 4'h0} >> 4);
	endtask : one_tick

	initial begin
		repeat (40000) @(posedge clock);
		miscompares++;
		stop_test;
	end

	initial begin
		repeat (10) @(posedge clock);
		rst_n <= 1'b1;
		rd_chk("ctrl", OFF_CTRL, 32'h3);
		rd_chk("div", OFF_DIV, 32'haa147);
		rd_chk("denom", OFF_DENOM, 32'h3e8);
		rd_chk("cal", OFF_CAL, 32'h7d010100);
		rd_chk("unmapped", 8'h3c, 32'h0);
		wr_reg(OFF_DENOM, 32'h2a5);
		rd_chk("denom", OFF_DENOM, 32'h2a5);
		// Frozen cases: nothing may move the guarded register
		for (int i = 0; i < 4; i++) begin
			timer_power_domain <= f_pwr[i];
			wr_reg(OFF_CTRL, f_ctl[i]);
			wr_reg(OFF_TIME, 32'h173b3b63);
			wr_reg(OFF_CAL, 32'h7d021c06);
			wr_reg(OFF_DIV, f_div[i]);
			repeat (40) @(posedge clock);
			wr_reg(OFF_DIV, 32'h0);
			rd_chk("frozen", f_reg[i], f_reg[i] == OFF_TIME ? 32'h173b3b63 : 32'h7d021c06);
		end
		timer_power_domain <= 1'b1;
		// Minute compare value is set but not enabled, so it must be ignored
		wr_reg(OFF_ALM_TIME, 32'h00050000);
		for (int i = 0; i < 5; i++) begin
			one_tick(i);
		end
		check("time_word", time_word, 32'h01600000);
		@(posedge clock);
		capture_trig <= 1'b1;
		@(posedge clock);
		capture_trig <= 1'b0;
		@(posedge clock);
		check("capture", {10'h0, timer_capture_value}, 32'h200000);
		// Interrupt enable, disable, set and clear
		wr_reg(OFF_FLAGS, 32'h3ff);
		wr_reg(OFF_FLAG_SET, 32'h201);
		rd_chk("flags", OFF_FLAGS, 32'h201);
		check("irq", {31'h0, irq}, 32'h0);
		wr_reg(OFF_INT_EN, 32'h3);
		rd_chk("mask", OFF_INT_MASK, 32'h3);
		check("irq", {31'h0, irq}, 32'h1);
		wr_reg(OFF_INT_DIS, 32'h1);
		rd_chk("mask", OFF_INT_MASK, 32'h2);
		check("irq", {31'h0, irq}, 32'h0);
		wr_reg(OFF_INT_EN, 32'h200);
		// Mask settles at the write edge, so look just after it
		#1;
		check("irq", {31'h0, irq}, 32'h1);
		rd_chk("int_en", OFF_INT_EN, 32'h0);
		wr_reg(OFF_FLAGS, 32'h200);
		#1;
		check("irq", {31'h0, irq}, 32'h0);
		wr_reg(OFF_FLAG_SET, 32'h2);
		#1;
		check("irq", {31'h0, irq}, 32'h1);
		// Software reset: kept, then cleared
		wr_reg(OFF_CTRL, 32'h8);
		wr_reg(OFF_TIME, 32'h173b3b63);
		wr_reg(OFF_CAL, 32'h7d021c06);
		@(posedge clock);
		sw_reset <= 1'b1;
		@(posedge clock);
		sw_reset <= 1'b0;
		rd_chk("keep", OFF_TIME, 32'h173b3b63);
		rd_chk("keep", OFF_CAL, 32'h7d021c06);
		wr_reg(OFF_CTRL, 32'h0);
		@(posedge clock);
		sw_reset <= 1'b1;
		@(posedge clock);
		sw_reset <= 1'b0;
		rd_chk("cleared", OFF_TIME, 32'h0);
		rd_chk("cleared", OFF_CAL, 32'h7d010100);
		rd_chk("div", OFF_DIV, 32'h0);
		stop_test;
	end
endmodule : tb
